/* common/arw_pkg.sv */
// Purpose: shared types and constants for the accumulator round and write-back path
// Assumes: 40-bit accumulators, 16-bit data words, byte-addressed data space
// Notes: the saturation stage sits outside this block
package arw_pkg;

	// ----------------------------------------------------------------
	// widths and constants
	// ----------------------------------------------------------------
	localparam int ARW_ACC_W = 40;
	localparam int ARW_WORD_W = 16;
	localparam int ARW_HI_MSB = 31;
	localparam int ARW_HI_LSB = 16;
	localparam int ARW_LO_MSB = 15;
	localparam logic [15:0] ARW_HALF_LSB = 16'h8000;
	localparam logic [15:0] ARW_PTR_STEP = 16'h0002;
	localparam logic [15:0] ARW_PTR_RST = 16'h0000;

	// ----------------------------------------------------------------
	// operation and mode encodings
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ARW_OP_NONE = 3'h0,
		ARW_OP_STORE_ACC = 3'h1,
		ARW_OP_STORE_ACC_RND = 3'h2,
		ARW_OP_MAC_CLASS = 3'h3,
		ARW_OP_MPY_ONLY = 3'h4,
		ARW_OP_MPY_NEG = 3'h5,
		ARW_OP_EUCL_DIST = 3'h6,
		ARW_OP_DIST_ACC = 3'h7
	} arw_op_t;

	typedef enum logic [1:0] {
		ARW_WB_NONE = 2'h0,
		ARW_WB_REG_DIRECT = 2'h1,
		ARW_WB_POST_INC = 2'h2
	} arw_wb_mode_t;

	typedef enum logic [2:0] {
		ARW_ST_IDLE = 3'b001,
		ARW_ST_SAT = 3'b010,
		ARW_ST_WRITE = 3'b100
	} arw_state_t;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		arw_op_t op;
		arw_wb_mode_t wb_mode;
		logic target_b;
		logic [15:0] st_addr;
	} arw_req_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data;
	} arw_xbus_t;

endpackage

/* rtl/arw_round.sv */
// Purpose: combinational round or truncate of an accumulator to a 1.15 word
// Assumes: round_mode_select_bit 0 conventional, 1 convergent
// Notes: no state at all
module arw_round
	import arw_pkg::*;
(
	// operand
	input wire logic [39:0] acc,
	// controls
	input wire logic rnd_en,
	input wire logic round_mode_select_bit,
	// result
	output logic [15:0] word
);
	import arw_pkg::*;

	logic [15:0] hi;
	logic [15:0] lo;
	logic inc;

	// ----------------------------------------------------------------
	// round decision
	// ----------------------------------------------------------------
	always_comb begin
		hi = acc[ARW_HI_MSB:ARW_HI_LSB];
		lo = acc[ARW_LO_MSB:0];
		inc = lo[ARW_LO_MSB]; // conventional: bit 15 added
		if (round_mode_select_bit && lo == ARW_HALF_LSB) begin
			inc = hi[0]; // tie goes to even
		end
		if (!rnd_en) begin
			inc = 1'b0; // truncation drops the low word
		end
		word = hi + {15'h0000, inc};
	end
endmodule

/* rtl/arw_ptr.sv */
// Purpose: write-back pointer register with post-increment
// Assumes: increment applied after the write has used the old value
// Notes: direct load wins over increment
module arw_ptr
	import arw_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// control
	input wire logic load,
	input wire logic [15:0] load_val,
	input wire logic inc,
	// value
	output logic [15:0] ptr
);
	import arw_pkg::*;

	logic [15:0] ptr_q;
	logic [15:0] ptr_d;

	// next pointer value
	always_comb begin
		ptr_d = ptr_q;
		if (load) begin
			ptr_d = load_val;
		end else if (inc) begin
			ptr_d = ptr_q + ARW_PTR_STEP;
		end
	end

	// pointer flop
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ptr_q <= ARW_PTR_RST;
		end else begin
			ptr_q <= ptr_d;
		end
	end

	assign ptr = ptr_q;
endmodule

/* rtl/arw_top.sv */
// Purpose: accumulator store and write-back path to the X bus
// Assumes: saturation stage external, returns a word one or more cycles later
// Notes: one request at a time; req_ready low while busy
module arw_top
	import arw_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// core control
	input wire logic round_mode_select_bit,
	// accumulators
	input wire logic [39:0] acc_a,
	input wire logic [39:0] acc_b,
	// request
	input wire logic req_valid,
	input wire arw_pkg::arw_req_t req,
	output logic req_ready,
	// saturation stage
	output logic sat_valid,
	output logic [15:0] sat_in,
	input wire logic sat_done,
	input wire logic [15:0] sat_out,
	// x bus
	output logic xbus_we,
	output arw_pkg::arw_xbus_t xbus,
	// pointer register view
	output logic [15:0] writeback_pointer_register
);
	import arw_pkg::*;

	// ----------------------------------------------------------------
	// request classification
	// ----------------------------------------------------------------
	logic is_store;
	logic is_mac_wb;
	logic rnd_en;
	logic [39:0] src_acc;
	logic [15:0] rnd_word;
	logic [15:0] ptr;

	always_comb begin
		is_store = (req.op == ARW_OP_STORE_ACC) || (req.op == ARW_OP_STORE_ACC_RND);
		is_mac_wb = (req.op == ARW_OP_MAC_CLASS) && (req.wb_mode != ARW_WB_NONE);
		rnd_en = is_mac_wb || (req.op == ARW_OP_STORE_ACC_RND);
		// write-back takes the accumulator the instruction does not target
		src_acc = (is_mac_wb ^ req.target_b) ? acc_b : acc_a;
	end

	arw_round u_round (
		.acc(src_acc),
		.rnd_en(rnd_en),
		.round_mode_select_bit(round_mode_select_bit),
		.word(rnd_word)
	);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	arw_state_t st_q, st_d;
	logic [15:0] addr_q, addr_d;
	logic [15:0] sat_in_q, sat_in_d;
	logic sat_valid_q, sat_valid_d;
	logic direct_q, direct_d;
	logic inc_q, inc_d;
	logic xbus_we_q, xbus_we_d;
	arw_xbus_t xbus_q, xbus_d;
	logic ptr_load;
	logic ptr_inc;

	// next-state and datapath
	always_comb begin
		st_d = st_q;
		addr_d = addr_q;
		sat_in_d = sat_in_q;
		sat_valid_d = 1'b0;
		direct_d = direct_q;
		inc_d = inc_q;
		xbus_we_d = 1'b0;
		xbus_d = xbus_q;
		ptr_load = 1'b0;
		ptr_inc = 1'b0;
		case (st_q)
			ARW_ST_IDLE: begin
				if (req_valid && (is_store || is_mac_wb)) begin
					sat_in_d = rnd_word;
					sat_valid_d = 1'b1;
					direct_d = is_mac_wb && (req.wb_mode == ARW_WB_REG_DIRECT);
					inc_d = is_mac_wb && (req.wb_mode == ARW_WB_POST_INC);
					addr_d = is_mac_wb ? ptr : req.st_addr;
					st_d = ARW_ST_SAT;
				end
			end
			ARW_ST_SAT: begin
				if (sat_done) begin
					if (direct_q) begin
						ptr_load = 1'b1;
						st_d = ARW_ST_IDLE;
					end else begin
						xbus_we_d = 1'b1;
						xbus_d.addr = addr_q;
						xbus_d.data = sat_out;
						st_d = ARW_ST_WRITE;
					end
				end
			end
			ARW_ST_WRITE: begin
				ptr_inc = inc_q;
				st_d = ARW_ST_IDLE;
			end
			default: begin
				st_d = ARW_ST_IDLE;
			end
		endcase
	end

	// sequencer flops
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_q <= ARW_ST_IDLE;
			addr_q <= 16'h0000;
			sat_in_q <= 16'h0000;
			sat_valid_q <= 1'b0;
			direct_q <= 1'b0;
			inc_q <= 1'b0;
			xbus_we_q <= 1'b0;
			xbus_q <= '0;
		end else begin
			st_q <= st_d;
			addr_q <= addr_d;
			sat_in_q <= sat_in_d;
			sat_valid_q <= sat_valid_d;
			direct_q <= direct_d;
			inc_q <= inc_d;
			xbus_we_q <= xbus_we_d;
			xbus_q <= xbus_d;
		end
	end

	arw_ptr u_ptr (
		.core_clk(core_clk),
		.rst(rst),
		.load(ptr_load),
		.load_val(sat_out),
		.inc(ptr_inc),
		.ptr(ptr)
	);

	// outputs straight from flops
	assign req_ready = st_q[0]; // idle bit of the one-hot state
	assign sat_valid = sat_valid_q;
	assign sat_in = sat_in_q;
	assign xbus_we = xbus_we_q;
	assign xbus = xbus_q;
	assign writeback_pointer_register = ptr;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_excluded_no_write;
		@(posedge core_clk) disable iff (rst)
		(req_valid && req_ready && req.op inside {ARW_OP_MPY_ONLY, ARW_OP_MPY_NEG, ARW_OP_EUCL_DIST,
			ARW_OP_DIST_ACC}) |=> !sat_valid;
	endproperty
	a_excluded_no_write: assert property (p_excluded_no_write) else $error("excluded op started store");

	property p_write_addr;
		@(posedge core_clk) disable iff (rst)
		(st_q == ARW_ST_SAT && sat_done && !direct_q) |=> (xbus_we && xbus.addr == addr_q && xbus.data == $past(sat_out));
	endproperty
	a_write_addr: assert property (p_write_addr) else $error("x bus write wrong");

	property p_direct_load;
		@(posedge core_clk) disable iff (rst)
		(st_q == ARW_ST_SAT && sat_done && direct_q) |=> (ptr == $past(sat_out) && !xbus_we);
	endproperty
	a_direct_load: assert property (p_direct_load) else $error("direct load failed");

	property p_post_inc;
		@(posedge core_clk) disable iff (rst)
		(xbus_we && inc_q) |=> (ptr == $past(xbus.addr) + ARW_PTR_STEP);
	endproperty
	a_post_inc: assert property (p_post_inc) else $error("pointer not advanced by two");

	property p_ptr_stable_during_write;
		@(posedge core_clk) disable iff (rst)
		(st_q == ARW_ST_SAT && inc_q) |=> $stable(ptr);
	endproperty
	a_ptr_stable_during_write: assert property (p_ptr_stable_during_write) else $error("pointer moved early");

	property p_sat_gets_round;
		@(posedge core_clk) disable iff (rst)
		(req_valid && req_ready && (is_store || is_mac_wb)) |=> (sat_valid && sat_in == $past(rnd_word));
	endproperty
	a_sat_gets_round: assert property (p_sat_gets_round) else $error("saturation input wrong");

	property p_truncate;
		@(posedge core_clk) disable iff (rst)
		(req_valid && req_ready && req.op == ARW_OP_STORE_ACC) |=> (sat_in == $past(src_acc[31:16]));
	endproperty
	a_truncate: assert property (p_truncate) else $error("truncation wrong");

	property p_conv_round;
		@(posedge core_clk) disable iff (rst)
		(req_valid && req_ready && rnd_en && !round_mode_select_bit)
		|=> (sat_in == 16'($past(src_acc[31:16]) + $past(src_acc[15])));
	endproperty
	a_conv_round: assert property (p_conv_round) else $error("conventional round wrong");

	property p_conv_tie;
		@(posedge core_clk) disable iff (rst)
		(req_valid && req_ready && rnd_en && round_mode_select_bit && src_acc[15:0] == ARW_HALF_LSB)
		|=> (sat_in == 16'($past(src_acc[31:16]) + $past(src_acc[16])));
	endproperty
	a_conv_tie: assert property (p_conv_tie) else $error("convergent tie wrong");

	property p_mac_rounds;
		@(posedge core_clk) disable iff (rst)
		(req_valid && req_ready && is_mac_wb && src_acc[15] && src_acc[15:0] != ARW_HALF_LSB)
		|=> (sat_in == 16'($past(src_acc[31:16]) + 16'h0001));
	endproperty
	a_mac_rounds: assert property (p_mac_rounds) else $error("write-back not rounded");

	property p_store_done;
		@(posedge core_clk) disable iff (rst)
		(st_q == ARW_ST_SAT && sat_done && !direct_q) |-> ##2 req_ready;
	endproperty
	a_store_done: assert property (p_store_done) else $error("store did not finish");

	property p_ready_drops;
		@(posedge core_clk) disable iff (rst)
		(req_valid && req_ready && (is_store || is_mac_wb)) |=> !req_ready;
	endproperty
	a_ready_drops: assert property (p_ready_drops) else $error("busy not shown after take");

	property p_sat_pulse;
		@(posedge core_clk) disable iff (rst)
		sat_valid |=> !sat_valid;
	endproperty
	a_sat_pulse: assert property (p_sat_pulse) else $error("saturation strobe longer than one cycle");

	property p_we_pulse;
		@(posedge core_clk) disable iff (rst)
		xbus_we |=> !xbus_we;
	endproperty
	a_we_pulse: assert property (p_we_pulse) else $error("bus write strobe longer than one cycle");

	property p_store_keeps_ptr;
		@(posedge core_clk) disable iff (rst)
		(xbus_we && !inc_q) |=> $stable(ptr);
	endproperty
	a_store_keeps_ptr: assert property (p_store_keeps_ptr) else $error("store moved the pointer");

	property p_idle_ptr_quiet;
		@(posedge core_clk) disable iff (rst)
		(st_q == ARW_ST_IDLE) |=> $stable(ptr);
	endproperty
	a_idle_ptr_quiet: assert property (p_idle_ptr_quiet) else $error("pointer moved while idle");

	property p_conv_nontie;
		@(posedge core_clk) disable iff (rst)
		(req_valid && req_ready && rnd_en && round_mode_select_bit && src_acc[15:0] != ARW_HALF_LSB)
		|=> (sat_in == 16'($past(src_acc[31:16]) + $past(src_acc[15])));
	endproperty
	a_conv_nontie: assert property (p_conv_nontie) else $error("convergent off-tie round wrong");

	property p_reset_quiet;
		@(posedge core_clk)
		rst |=> (!sat_valid && !xbus_we && req_ready && ptr == ARW_PTR_RST);
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet after reset");

	property p_store_addr;
		@(posedge core_clk) disable iff (rst)
		(req_valid && req_ready && is_store) |=> (addr_q == $past(req.st_addr));
	endproperty
	a_store_addr: assert property (p_store_addr) else $error("store address not captured");

	property p_wb_addr;
		@(posedge core_clk) disable iff (rst)
		(req_valid && req_ready && is_mac_wb) |=> (addr_q == $past(ptr));
	endproperty
	a_wb_addr: assert property (p_wb_addr) else $error("write-back address not the pointer");

	property p_src_select;
		@(posedge core_clk) disable iff (rst)
		(req_valid && req_ready && is_mac_wb && !round_mode_select_bit)
		|=> (sat_in == 16'($past(req.target_b ? acc_a[31:16] : acc_b[31:16])
			+ $past(req.target_b ? acc_a[15] : acc_b[15])));
	endproperty
	a_src_select: assert property (p_src_select) else $error("write-back used target accumulator");

	c_post_inc: cover property (@(posedge core_clk) xbus_we && inc_q);
	c_direct: cover property (@(posedge core_clk) ptr_load);
	c_store: cover property (@(posedge core_clk) xbus_we && !inc_q);
	c_tie: cover property (@(posedge core_clk) req_valid && rnd_en && src_acc[15:0] == ARW_HALF_LSB);
endmodule

/* tb/arw_sat_mem.sv */
// Purpose: saturation stage and data memory stand-in
// Assumes: one word in flight at a time
// Notes: answer delay and word alteration come from the bench
module arw_sat_mem
	import arw_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// saturation side
	input wire logic sat_valid,
	input wire logic [15:0] sat_in,
	input wire logic [3:0] dly,
	input wire logic [15:0] alt,
	output logic sat_done,
	output logic [15:0] sat_out,
	// x bus side
	input wire logic xbus_we,
	input wire arw_pkg::arw_xbus_t xbus
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	logic [15:0] hold = 16'h0000;
	logic [15:0] mem [logic [15:0]];

	// ----------------------------------------------------------------
	// delayed answer; the word is invalid outside the done pulse
	// ----------------------------------------------------------------
	always @(posedge core_clk) begin
		sat_done <= 1'b0;
		sat_out <= ~hold;
		if (rst) begin
			cnt <= 0;
		end else if (sat_valid) begin
			hold <= sat_in ^ alt;
			cnt <= dly + 1;
		end else if (cnt == 1) begin
			sat_done <= 1'b1;
			sat_out <= hold;
			cnt <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
		if (xbus_we) begin
			mem[xbus.addr] = xbus.data;
		end
	end
endmodule

/* tb/tb_arw_top.sv */
// Purpose: self-checking bench for the store and write-back path
// Assumes: partner returns the word altered by alt dly+1 cycles after it samples sat_valid
// Notes: corner table first, then the excluded ops, then fixed-seed random requests
module tb_arw_top;
	timeunit 1ns;
	timeprecision 1ps;
	import arw_pkg::*;

	logic core_clk = 0, rst = 1, rmode = 0, req_valid = 0;
	logic [39:0] acc_a = 0, acc_b = 0;
	arw_req_t req = '0;
	logic req_ready, sat_valid, sat_done, xbus_we;
	logic [15:0] sat_in, sat_out, wptr, alt = 0, got_sat, got_addr, got_data;
	logic [15:0] lo_tab [4] = '{16'h8000, 16'h7fff, 16'hffff, 16'h0000};
	logic [3:0] dly = 0;
	arw_xbus_t xbus;
	int err_total = 0, n_tests = 0, n_sat = 0, n_wr = 0;
	logic [31:0] lf = 32'hc61a40c2;

	always #4 core_clk = ~core_clk;

	arw_top DUT (.core_clk(core_clk), .rst(rst), .round_mode_select_bit(rmode), .acc_a(acc_a), .acc_b(acc_b),
		.req_valid(req_valid), .req(req), .req_ready(req_ready), .sat_valid(sat_valid), .sat_in(sat_in),
		.sat_done(sat_done), .sat_out(sat_out), .xbus_we(xbus_we), .xbus(xbus), .writeback_pointer_register(wptr));
	arw_sat_mem u_mem (.core_clk(core_clk), .rst(rst), .sat_valid(sat_valid), .sat_in(sat_in), .dly(dly),
		.alt(alt), .sat_done(sat_done), .sat_out(sat_out), .xbus_we(xbus_we), .xbus(xbus));

	// monitor of saturation hand-offs and bus writes
	always @(posedge core_clk) begin
		if (sat_valid === 1'b1) begin
			n_sat++;
			got_sat = sat_in;
		end
		if (xbus_we === 1'b1) begin
			n_wr++;
			got_addr = xbus.addr;
			got_data = xbus.data;
		end
	end

	function automatic logic [31:0] rnd32();
		repeat (32) lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf;
	endfunction

	// expected rounded or truncated high word
	function automatic logic [15:0] exp_word(logic [39:0] a, logic rn, logic m);
		if (!rn) return a[31:16];
		if (m && a[15:0] == 16'h8000) return a[31:16] + {15'h0000, a[16]};
		return a[31:16] + {15'h0000, a[15]};
	endfunction

	task automatic chk(logic [15:0] g, logic [15:0] e);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// one request, then checks on the hand-off, the bus and the pointer
	task automatic run(arw_op_t op, arw_wb_mode_t wb, logic tb, logic [15:0] sa, logic [39:0] a,
		logic [39:0] b, logic m);
		logic [15:0] p0, e;
		int s0, w0, k;
		logic taken, mac, wr;
		p0 = wptr;
		s0 = n_sat;
		w0 = n_wr;
		mac = op == ARW_OP_MAC_CLASS;
		taken = op inside {ARW_OP_STORE_ACC, ARW_OP_STORE_ACC_RND} || (mac && wb != ARW_WB_NONE);
		wr = taken && (!mac || wb == ARW_WB_POST_INC);
		e = exp_word((mac ^ tb) ? b : a, op != ARW_OP_STORE_ACC, m);
		@(posedge core_clk);
		acc_a <= a;
		acc_b <= b;
		rmode <= m;
		req <= '{op, wb, tb, sa};
		req_valid <= 1'b1;
		@(posedge core_clk);
		req_valid <= 1'b0;
		k = 0;
		repeat (2) @(posedge core_clk);
		#1;
		while (req_ready !== 1'b1 && k < 40) begin
			@(posedge core_clk);
			#1;
			k++;
		end
		if (k == 40) begin
			err_total++;
			final_report();
		end
		@(posedge core_clk);
		#1;
		chk(16'(n_sat - s0), {15'h0000, taken});
		if (taken) chk(got_sat, e);
		e = e ^ alt;
		chk(16'(n_wr - w0), {15'h0000, wr});
		if (wr) chk(got_addr, mac ? p0 : sa);
		if (wr) chk(got_data, e);
		chk(wptr, !(taken && mac) ? p0 : (wb == ARW_WB_REG_DIRECT ? e : p0 + ARW_PTR_STEP));
	endtask

	initial begin
		logic [31:0] r;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		#1;
		chk(wptr, ARW_PTR_RST);
		// rounding ties and boundaries, both modes, odd and even high word
		for (int c = 0; c < 16; c++) begin
			run(ARW_OP_MAC_CLASS, ARW_WB_POST_INC, 1'b0, 16'h0000, 40'h00_0000_0000,
				{8'h00, (c[3] ? 16'h0011 : 16'hfff0), lo_tab[c[1:0]]}, c[2]);
		end
		$display("test corner done");
		for (int o = 4; o < 8; o++) run(arw_op_t'(o[2:0]), ARW_WB_POST_INC, 1'b1, 16'h0000, 40'hff_0000_8000,
			40'h00_1234_8000, 1'b0);
		$display("test excluded done");
		for (int i = 0; i < 300; i++) begin
			r = rnd32();
			dly <= r[3:0];
			alt <= r[4] ? r[31:16] : 16'h0000;
			run(arw_op_t'(r[7:5]), arw_wb_mode_t'(r[9:8] % 3), r[10], r[31:16], 40'({rnd32(), rnd32()}),
				40'({rnd32(), rnd32()}), r[11]);
		end
		$display("test random done");
		final_report();
	end
endmodule
